// *** include/ttpc_consts.svh ***
`ifndef TTPC_CONSTS_SVH
`define TTPC_CONSTS_SVH

// -----------------------------------------------------------------------------
// Register map, byte addresses on the register bus.
// -----------------------------------------------------------------------------
`define TTPC_TIMER_ZERO_CTRL_STAT 8'h00
`define TTPC_TIMER_ONE_CTRL_STAT  8'h10
`define TTPC_TIMER_TWO_CTRL_STAT  8'h20
`define TTPC_POWER_CTRL           8'h30
`define TTPC_TIMER_STRIDE         8'h10

// Word index of each register inside one timer's group.
`define TTPC_REG_CTRL_STAT        2'h0
`define TTPC_REG_COMPARE          2'h1
`define TTPC_REG_DUTY             2'h2
`define TTPC_REG_COUNT            2'h3

// -----------------------------------------------------------------------------
// Field positions and reset values.
// -----------------------------------------------------------------------------
`define TTPC_POS_PIN_LVL          8
`define TTPC_POS_FLAG             9
`define TTPC_POS_DRV              10
`define TTPC_POS_STOP             0
`define TTPC_POS_WAIT             1
`define TTPC_CTRL_RST             8'h00
`define TTPC_WORD_RST             32'h0000_0000

// -----------------------------------------------------------------------------
// Bus responses.
// -----------------------------------------------------------------------------
`define TTPC_RESP_OKAY            2'h0
`define TTPC_RESP_SLVERR          2'h2

`endif

// *** include/ttpc_pkg.sv ***
package ttpc_pkg;

  // ---------------------------------------------------------------------------
  // Timer modes.
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    TTPC_MODE_GPIO  = 3'h0,
    TTPC_MODE_TIMER = 3'h1,
    TTPC_MODE_WDOG  = 3'h2,
    TTPC_MODE_PWM   = 3'h3,
    TTPC_MODE_EVENT = 3'h4,
    TTPC_MODE_MEAS  = 3'h5
  } ttpc_mode_t;

  // ---------------------------------------------------------------------------
  // Writable part of a control and status register.
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic       gpio_lvl;
    logic       gpio_dir;
    logic       irq_en;
    logic       ext_clk;
    ttpc_mode_t mode;
    logic       enable;
  } ttpc_ctrl_t;

  // ---------------------------------------------------------------------------
  // Write channel state.
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    TTPC_WR_IDLE = 2'h1,
    TTPC_WR_RESP = 2'h2
  } ttpc_wr_state_t;

endpackage

// *** hw/ttpc_top.sv ***
// Notes on behaviour
// - Three identical independent timers, each with own control and pin.
// - Each timer counts the internal clock or external events on its pin.
// - A timer raises an interrupt after a programmed number of events.
// - A timer drives its pin toward a device after programmed internal counts.
// - Event counter and measurement modes use the pin as an input.
// - Watchdog, timer and pulse modulation modes drive the pin as output.
// - After reset pins are inputs; only control writes change that.
// - In stop, inputs are ignored and driven pins go high impedance.
// - Wait state never changes pin direction or level.

`include "ttpc_consts.svh"

module ttpc_top (
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address.
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic [2:0]  awprot,
  // AXI4-Lite write data.
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  // AXI4-Lite write response.
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  // AXI4-Lite read address.
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  input  wire logic [2:0]  arprot,
  // AXI4-Lite read data.
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  // Timer pins.
  input  wire logic        timer_zero_pin_lvl,
  output logic             timer_zero_pin_drv,
  output logic             timer_zero_pin_oe_n,
  input  wire logic        timer_one_pin_lvl,
  output logic             timer_one_pin_drv,
  output logic             timer_one_pin_oe_n,
  input  wire logic        timer_two_pin_lvl,
  output logic             timer_two_pin_drv,
  output logic             timer_two_pin_oe_n,
  // Interrupt requests, one per timer.
  output logic [2:0]       timer_irq
);

  // ---------------------------------------------------------------------------
  // Bus slave state.
  // ---------------------------------------------------------------------------
  ttpc_pkg::ttpc_wr_state_t wr_state_q;
  logic                     awready_q;
  logic                     wready_q;
  logic                     bvalid_q;
  logic [1:0]               bresp_q;
  logic                     arready_q;
  logic                     rvalid_q;
  logic [31:0]              rdata_q;
  logic [1:0]               rresp_q;
  logic                     aw_got_q;
  logic                     w_got_q;
  logic [7:0]               waddr_q;
  logic [31:0]              wdata_q;
  logic [3:0]               wstrb_q;
  logic                     stop_q;
  logic                     wait_q;

  // ---------------------------------------------------------------------------
  // Timer state.
  // ---------------------------------------------------------------------------
  ttpc_pkg::ttpc_ctrl_t ctrl_q [3];
  logic [31:0]          cmp_q  [3];
  logic [31:0]          duty_q [3];
  logic [31:0]          cnt_q  [3];
  logic [31:0]          cap_q  [3];
  logic [2:0]           flag_q;
  logic [2:0]           drv_q;
  logic [2:0]           oe_n_q;
  logic [2:0]           irq_q;
  logic [2:0]           sync_lvl;
  logic [2:0]           pin_raw;

  assign pin_raw = {timer_two_pin_lvl, timer_one_pin_lvl, timer_zero_pin_lvl};

  // ---------------------------------------------------------------------------
  // Byte lane merge.
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] ttpc_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // ---------------------------------------------------------------------------
  // Address decode.
  // ---------------------------------------------------------------------------
  wire       wr_fire    = (wr_state_q == ttpc_pkg::TTPC_WR_IDLE) && aw_got_q && w_got_q;
  wire [1:0] wr_idx     = waddr_q[5:4];
  wire [1:0] wr_reg     = waddr_q[3:2];
  wire       wr_power   = (waddr_q[7:2] == 6'(`TTPC_POWER_CTRL >> 2));
  wire       wr_timer   = (waddr_q[7:6] == 2'h0) && (wr_idx != 2'h3);
  wire       wr_ok      = wr_power || wr_timer;
  wire       ar_fire    = arvalid && arready_q;
  wire [1:0] rd_idx     = araddr[5:4];
  wire [1:0] rd_reg     = araddr[3:2];
  wire       rd_power   = (araddr[7:2] == 6'(`TTPC_POWER_CTRL >> 2));
  wire       rd_timer   = (araddr[7:6] == 2'h0) && (rd_idx != 2'h3);
  wire       flag_clr_b = wstrb_q[1] && wdata_q[`TTPC_POS_FLAG];

  // ---------------------------------------------------------------------------
  // Read data selection.
  // ---------------------------------------------------------------------------
  logic [31:0] rd_word;
  always_comb begin
    rd_word = `TTPC_WORD_RST;
    if (rd_power) begin
      rd_word[`TTPC_POS_STOP] = stop_q;
      rd_word[`TTPC_POS_WAIT] = wait_q;
    end else if (rd_timer && rd_reg == `TTPC_REG_CTRL_STAT) begin
      rd_word[7:0]               = ctrl_q[rd_idx];
      rd_word[`TTPC_POS_PIN_LVL] = sync_lvl[rd_idx];
      rd_word[`TTPC_POS_FLAG]    = flag_q[rd_idx];
      rd_word[`TTPC_POS_DRV]     = drv_q[rd_idx];
    end else if (rd_timer && rd_reg == `TTPC_REG_COMPARE) begin
      rd_word = cmp_q[rd_idx];
    end else if (rd_timer && rd_reg == `TTPC_REG_DUTY) begin
      rd_word = duty_q[rd_idx];
    end else if (rd_timer) begin
      rd_word = (ctrl_q[rd_idx].mode == ttpc_pkg::TTPC_MODE_MEAS) ? cap_q[rd_idx] : cnt_q[rd_idx];
    end
  end

  // ---------------------------------------------------------------------------
  // Write channels.
  // ---------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_q <= ttpc_pkg::TTPC_WR_IDLE;
      awready_q  <= 1'b1;
      wready_q   <= 1'b1;
      aw_got_q   <= 1'b0;
      w_got_q    <= 1'b0;
      waddr_q    <= 8'h00;
      wdata_q    <= `TTPC_WORD_RST;
      wstrb_q    <= 4'h0;
      bvalid_q   <= 1'b0;
      bresp_q    <= `TTPC_RESP_OKAY;
    end else begin
      case (wr_state_q)
        ttpc_pkg::TTPC_WR_IDLE: begin
          if (awvalid && awready_q) begin
            aw_got_q  <= 1'b1;
            awready_q <= 1'b0;
            waddr_q   <= awaddr;
          end
          if (wvalid && wready_q) begin
            w_got_q  <= 1'b1;
            wready_q <= 1'b0;
            wdata_q  <= wdata;
            wstrb_q  <= wstrb;
          end
          if (wr_fire) begin
            bvalid_q   <= 1'b1;
            bresp_q    <= wr_ok ? `TTPC_RESP_OKAY : `TTPC_RESP_SLVERR;
            wr_state_q <= ttpc_pkg::TTPC_WR_RESP;
          end
        end
        ttpc_pkg::TTPC_WR_RESP: begin
          if (bready) begin
            bvalid_q   <= 1'b0;
            aw_got_q   <= 1'b0;
            w_got_q    <= 1'b0;
            awready_q  <= 1'b1;
            wready_q   <= 1'b1;
            wr_state_q <= ttpc_pkg::TTPC_WR_IDLE;
          end
        end
        default: begin
          wr_state_q <= ttpc_pkg::TTPC_WR_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Read channels.
  // ---------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= `TTPC_WORD_RST;
      rresp_q   <= `TTPC_RESP_OKAY;
    end else if (ar_fire) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_word;
      rresp_q   <= (rd_power || rd_timer) ? `TTPC_RESP_OKAY : `TTPC_RESP_SLVERR;
    end else if (rvalid_q && rready) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Power states.
  // ---------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stop_q <= 1'b0;
      wait_q <= 1'b0;
    end else if (wr_fire && wr_power && wstrb_q[0]) begin
      stop_q <= wdata_q[`TTPC_POS_STOP];
      wait_q <= wdata_q[`TTPC_POS_WAIT];
    end
  end

  // ---------------------------------------------------------------------------
  // Timer units.
  // ---------------------------------------------------------------------------
  for (genvar i = 0; i < 3; i++) begin : g_timer
    logic                 sy1_q;
    logic                 sy2_q;
    logic                 sy3_q;
    ttpc_pkg::ttpc_ctrl_t c;
    logic [31:0]          cnt_d;
    logic                 drv_d;

    assign c = ctrl_q[i];
    wire sel      = wr_fire && wr_timer && (wr_idx == 2'(i));
    wire wr_ctrl  = sel && (wr_reg == `TTPC_REG_CTRL_STAT) && wstrb_q[0];
    wire flag_clr = sel && (wr_reg == `TTPC_REG_CTRL_STAT) && flag_clr_b;
    wire is_meas  = (c.mode == ttpc_pkg::TTPC_MODE_MEAS);
    wire is_in    = is_meas || (c.mode == ttpc_pkg::TTPC_MODE_EVENT)
                    || (c.mode == ttpc_pkg::TTPC_MODE_GPIO && !c.gpio_dir);
    wire run      = c.enable && !stop_q && (c.mode != ttpc_pkg::TTPC_MODE_GPIO);
    wire rise     = sy2_q && !sy3_q;
    wire fall     = !sy2_q && sy3_q;
    wire ext      = is_in && (c.ext_clk || c.mode == ttpc_pkg::TTPC_MODE_EVENT);
    wire tick     = ext ? rise : 1'b1;
    wire at_top   = (cnt_q[i] == cmp_q[i]);
    wire hit      = run && (is_meas ? fall : (tick && at_top));

    assign sync_lvl[i] = sy2_q;

    always_comb begin
      cnt_d = cnt_q[i];
      if (!c.enable) begin
        cnt_d = `TTPC_WORD_RST;
      end else if (run && is_meas) begin
        cnt_d = fall ? `TTPC_WORD_RST : (sy2_q ? cnt_q[i] + 32'h0000_0001 : cnt_q[i]);
      end else if (run && tick) begin
        cnt_d = at_top ? `TTPC_WORD_RST : cnt_q[i] + 32'h0000_0001;
      end
    end

    always_comb begin
      drv_d = drv_q[i];
      case (c.mode)
        ttpc_pkg::TTPC_MODE_GPIO:  drv_d = c.gpio_lvl;
        ttpc_pkg::TTPC_MODE_TIMER: drv_d = c.enable && (hit ? !drv_q[i] : drv_q[i]);
        ttpc_pkg::TTPC_MODE_WDOG:  drv_d = c.enable && (hit || drv_q[i]);
        ttpc_pkg::TTPC_MODE_PWM:   drv_d = c.enable && (cnt_q[i] < duty_q[i]);
        default:                   drv_d = 1'b0;
      endcase
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        sy1_q     <= 1'b0;
        sy2_q     <= 1'b0;
        sy3_q     <= 1'b0;
        ctrl_q[i] <= `TTPC_CTRL_RST;
        cmp_q[i]  <= `TTPC_WORD_RST;
        duty_q[i] <= `TTPC_WORD_RST;
        cnt_q[i]  <= `TTPC_WORD_RST;
        cap_q[i]  <= `TTPC_WORD_RST;
        flag_q[i] <= 1'b0;
        drv_q[i]  <= 1'b0;
        oe_n_q[i] <= 1'b1;
        irq_q[i]  <= 1'b0;
      end else begin
        sy1_q     <= pin_raw[i];
        sy2_q     <= sy1_q;
        sy3_q     <= sy2_q;
        cnt_q[i]  <= cnt_d;
        drv_q[i]  <= stop_q ? drv_q[i] : drv_d;
        oe_n_q[i] <= is_in || stop_q;
        flag_q[i] <= hit || (flag_q[i] && !flag_clr);
        irq_q[i]  <= flag_q[i] && c.irq_en;
        if (hit && is_meas) begin
          cap_q[i] <= cnt_q[i];
        end
        if (wr_ctrl) begin
          ctrl_q[i] <= wdata_q[7:0];
        end
        if (sel && wr_reg == `TTPC_REG_COMPARE) begin
          cmp_q[i] <= ttpc_merge(cmp_q[i], wdata_q, wstrb_q);
        end
        if (sel && wr_reg == `TTPC_REG_DUTY) begin
          duty_q[i] <= ttpc_merge(duty_q[i], wdata_q, wstrb_q);
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs.
  // ---------------------------------------------------------------------------
  assign awready             = awready_q;
  assign wready              = wready_q;
  assign bvalid              = bvalid_q;
  assign bresp               = bresp_q;
  assign arready             = arready_q;
  assign rvalid              = rvalid_q;
  assign rdata               = rdata_q;
  assign rresp               = rresp_q;
  assign timer_zero_pin_drv  = drv_q[0];
  assign timer_zero_pin_oe_n = oe_n_q[0];
  assign timer_one_pin_drv   = drv_q[1];
  assign timer_one_pin_oe_n  = oe_n_q[1];
  assign timer_two_pin_drv   = drv_q[2];
  assign timer_two_pin_oe_n  = oe_n_q[2];
  assign timer_irq           = irq_q;

endmodule // ttpc_top

// *** tb/ttpc_asserts.sv ***
`include "ttpc_consts.svh"

module ttpc_asserts (
  // Clock and reset.
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus.
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  // Pins and interrupts.
  input wire logic        timer_zero_pin_oe_n,
  input wire logic        timer_one_pin_oe_n,
  input wire logic        timer_two_pin_oe_n,
  input wire logic [2:0]  timer_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------
  // Checks.
  // --------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [3:0] whs_q;
  logic [2:0] oe_n;
  assign oe_n = {timer_two_pin_oe_n, timer_one_pin_oe_n, timer_zero_pin_oe_n};
  always_ff @(posedge aclk) begin
    whs_q <= aresetn ? {whs_q[2:0], wvalid & wready} : 4'h0;
  end
  property p_rst;
    $rose(aresetn) |-> oe_n == 3'h7 && timer_irq == 3'h0 && awready && !bvalid;
  endproperty
  a_rst: assert property (p_rst) else $error("pins or irq wrong after reset");
  property p_oe;
    $changed(oe_n) |-> whs_q != 4'h0;
  endproperty
  a_oe: assert property (p_oe) else $error("pin direction changed without write");
  property p_irq;
    whs_q == 4'h0 |=> (timer_irq & $past(timer_irq)) == $past(timer_irq);
  endproperty
  a_irq: assert property (p_irq) else $error("irq dropped without write");
  property p_blat;
    awvalid && awready && wvalid && wready |-> ##2 bvalid;
  endproperty
  a_blat: assert property (p_blat) else $error("write response late");
  property p_refuse;
    awvalid && awready |=> !awready [*2];
  endproperty
  a_refuse: assert property (p_refuse) else $error("second write address accepted");
  property p_rlat;
    arvalid && arready |=> rvalid && !arready;
  endproperty
  a_rlat: assert property (p_rlat) else $error("read data late");
  property p_bstand;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_bstand: assert property (p_bstand) else $error("write response not held");
  property p_rstand;
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
  endproperty
  a_rstand: assert property (p_rstand) else $error("read data not held");
  c_slverr: cover property (bvalid && bresp == `TTPC_RESP_SLVERR);
  c_irq: cover property (timer_irq != 3'h0);
  c_out: cover property (!timer_zero_pin_oe_n);
endmodule // ttpc_asserts

bind ttpc_top ttpc_asserts u_chk (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready,
  .bresp, .arvalid, .arready, .rvalid, .rready, .rdata, .rresp, .timer_zero_pin_oe_n,
  .timer_one_pin_oe_n, .timer_two_pin_oe_n, .timer_irq);

// *** tb/ttpc_pin_model.sv ***
module ttpc_pin_model (
  // Clock.
  input  wire logic       aclk,
  // Pin lines.
  input  wire logic [2:0] drv,
  input  wire logic [2:0] oe_n,
  output logic      [2:0] lvl
);
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------
  // External source.
  // --------------------
  logic [2:0] ev_q = 3'h0;
  assign lvl = (~oe_n & drv) | (oe_n & ev_q);
  task automatic pulse(input int i, input int n);
    @(posedge aclk);
    ev_q[i] <= 1'b1;
    repeat (n) @(posedge aclk);
    ev_q[i] <= 1'b0;
  endtask
endmodule // ttpc_pin_model

// *** tb/testbench.sv ***
`include "ttpc_consts.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] w;
    logic [31:0] r;
    logic [1:0]  s;
  } ttpc_row_t;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0]  wstrb = 4'h0;
  logic        awready, wready, bvalid, arready, rvalid, p;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [2:0]  irq, drv, oe_n, lvl;
  int          err_total = 0;
  int          checks = 0;
  int          cyc = 0;
  int          n;
  ttpc_row_t   rows [8] = '{
    '{8'h04, 32'h0000_0005, 32'h0000_0005, `TTPC_RESP_OKAY},
    '{8'h14, 32'hA5A5_5A5A, 32'hA5A5_5A5A, `TTPC_RESP_OKAY},
    '{8'h28, 32'h0000_1234, 32'h0000_1234, `TTPC_RESP_OKAY},
    '{8'h0C, 32'hFFFF_FFFF, 32'h0000_0000, `TTPC_RESP_OKAY},
    '{8'h10, 32'hFFFF_F848, 32'h0000_0048, `TTPC_RESP_OKAY},
    '{8'h10, 32'h0000_0000, 32'h0000_0000, `TTPC_RESP_OKAY},
    '{8'h34, 32'h1111_1111, 32'h0000_0000, `TTPC_RESP_SLVERR},
    '{8'hFC, 32'h2222_2222, 32'h0000_0000, `TTPC_RESP_SLVERR}};

  ttpc_top uut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata,
    .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready,
    .rdata, .rresp, .timer_zero_pin_lvl(lvl[0]), .timer_zero_pin_drv(drv[0]),
    .timer_zero_pin_oe_n(oe_n[0]), .timer_one_pin_lvl(lvl[1]), .timer_one_pin_drv(drv[1]),
    .timer_one_pin_oe_n(oe_n[1]), .timer_two_pin_lvl(lvl[2]), .timer_two_pin_drv(drv[2]),
    .timer_two_pin_oe_n(oe_n[2]), .timer_irq(irq));
  ttpc_pin_model pm (.aclk, .drv, .oe_n, .lvl);

  // --------------------
  // Helpers.
  // --------------------
  initial forever #50 aclk = ~aclk;
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dv);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= dv;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready && !ad) awvalid <= 1'b0;
      if (wready && !wd) wvalid <= 1'b0;
      ad = ad | awready;
      wd = wd | wready;
    end while (!(ad && wd));
    while (!bvalid) @(posedge aclk);
    bready <= 1'b1;
    @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    rready <= 1'b1;
    @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // --------------------
  // Tests.
  // --------------------
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("oe_n", oe_n, 3'h7);
    chk("irq", irq, 3'h0);
    rd(8'h00);
    chk("ctrl", d, 32'h0000_0000);
    $display("test reset done");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      chk("bresp", r, rows[i].s);
      rd(rows[i].a);
      chk("rdata", d, rows[i].r);
      chk("rresp", r, rows[i].s);
    end
    $display("test registers done");
    for (int t = 0; t < 3; t++) begin
      for (int m = 0; m < 7; m++) begin
        wr(8'(t * 16), 32'(m % 6 * 2));
        repeat (2) @(posedge aclk);
        chk("oe_n", oe_n, 3'h7 & ~(3'(m % 6 > 0 && m % 6 < 4) << t));
      end
    end
    $display("test modes done");
    wr(8'h04, 32'h0000_0003);
    wr(8'h00, 32'h0000_0003);
    p = drv[0];
    n = 0;
    repeat (16) begin
      @(posedge aclk);
      if (drv[0] !== p) n++;
      p = drv[0];
    end
    chk("toggles", 32'(n), 32'h0000_0004);
    chk("oe_n", oe_n, 3'h6);
    wr(8'h00, 32'h0000_0023);
    repeat (8) @(posedge aclk);
    chk("irq", irq, 3'h1);
    wr(8'h00, 32'h0000_0020);
    repeat (10) @(posedge aclk);
    chk("irq", irq, 3'h1);
    wr(8'h00, 32'h0000_0220);
    repeat (3) @(posedge aclk);
    chk("irq", irq, 3'h0);
    $display("test timer done");
    wr(8'h24, 32'h0000_0002);
    wr(8'h20, 32'h0000_0039);
    pm.pulse(2, 2);
    repeat (4) @(posedge aclk);
    pm.pulse(2, 6);
    repeat (8) @(posedge aclk);
    chk("irq", irq, 3'h0);
    pm.pulse(2, 2);
    repeat (8) @(posedge aclk);
    chk("irq", irq, 3'h4);
    $display("test events done");
    wr(8'h20, 32'h0000_0239);
    wr(8'h00, 32'h0000_0003);
    wr(8'h30, 32'h0000_0001);
    repeat (2) @(posedge aclk);
    chk("oe_n", oe_n, 3'h7);
    repeat (3) pm.pulse(2, 2);
    repeat (8) @(posedge aclk);
    chk("irq", irq, 3'h0);
    wr(8'h30, 32'h0000_0000);
    repeat (2) @(posedge aclk);
    chk("oe_n", oe_n, 3'h6);
    wr(8'h10, 32'h0000_00C0);
    wr(8'h30, 32'h0000_0002);
    repeat (4) @(posedge aclk);
    chk("oe_n", oe_n, 3'h4);
    chk("drv", drv[1], 1'b1);
    $display("test stop and wait done");
    wr(8'h20, 32'h0000_020B);
    pm.pulse(2, 5);
    repeat (6) @(posedge aclk);
    rd(8'h2C);
    chk("width", d, 32'h0000_0005);
    chk("drv", drv[2], 1'b0);
    $display("test measure done");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("oe_n", oe_n, 3'h7);
    chk("irq", irq, 3'h0);
    rd(8'h04);
    chk("compare", d, 32'h0000_0000);
    $display("test second reset done");
    wrap_up();
  end
endmodule // testbench
